// ---- rtl/dhb_chop.v ----
`timescale 1ns/1ps
// ****************************************
// Per-bridge chopping and overcurrent sequencer
// ****************************************
module dhb_chop (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Control
  input  wire       run,
  input  wire       sense_trip,
  input  wire       ocp_raw,
  // Status
  output wire       drive_en,
  output wire       ocp_fault
);
`include "dhb_map.vh"
  localparam [`DHB_CNT_W-1:0] BLANK_N = `DHB_BLANK_CYC;
  localparam [`DHB_CNT_W-1:0] OFF_N   = `DHB_OFF_CYC;
  localparam [`DHB_CNT_W-1:0] DEG_N   = `DHB_DEG_CYC;
  localparam [`DHB_CNT_W-1:0] RETRY_N = `DHB_RETRY_CYC;
  localparam [`DHB_CNT_W-1:0] ONE     = 16'h0001;

  reg [1:0]            st_reg;
  reg [1:0]            st_next;
  reg [`DHB_CNT_W-1:0] cnt_reg;
  reg [`DHB_CNT_W-1:0] cnt_next;
  reg [`DHB_CNT_W-1:0] deg_reg;
  reg [`DHB_CNT_W-1:0] deg_next;

  assign drive_en  = (st_reg == `DHB_ST_ON);
  assign ocp_fault = (st_reg == `DHB_ST_RETRY);

  always @(posedge sys_clk) begin
    if (rst) begin
      st_reg  <= `DHB_ST_ON;
      cnt_reg <= 16'h0000;
      deg_reg <= 16'h0000;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      deg_reg <= deg_next;
    end
  end

  always @* begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    deg_next = 16'h0000;
    if (!run) begin
      st_next  = `DHB_ST_ON;
      cnt_next = 16'h0000;
    end else begin
      // Deglitch counter runs while indication persists
      if (ocp_raw && st_reg != `DHB_ST_RETRY)
        deg_next = (deg_reg == DEG_N) ? deg_reg : deg_reg + ONE;
      case (st_reg)
        `DHB_ST_ON: begin
          if (cnt_reg < BLANK_N)
            cnt_next = cnt_reg + ONE;
          if (deg_next == DEG_N) begin
            st_next  = `DHB_ST_RETRY;
            cnt_next = 16'h0000;
          end else if (cnt_reg >= BLANK_N && sense_trip) begin
            st_next  = `DHB_ST_OFF;
            cnt_next = 16'h0000;
          end
        end
        `DHB_ST_OFF: begin
          cnt_next = cnt_reg + ONE;
          if (deg_next == DEG_N) begin
            st_next  = `DHB_ST_RETRY;
            cnt_next = 16'h0000;
          end else if (cnt_reg == OFF_N - ONE) begin
            st_next  = `DHB_ST_ON;
            cnt_next = 16'h0000;
          end
        end
        `DHB_ST_RETRY: begin
          cnt_next = cnt_reg + ONE;
          if (cnt_reg == RETRY_N - ONE) begin
            st_next  = `DHB_ST_ON;
            cnt_next = 16'h0000;
          end
        end
        default: begin
          st_next  = `DHB_ST_ON;
          cnt_next = 16'h0000;
        end
      endcase
    end
  end
endmodule // dhb_chop

// ---- rtl/dhb_map.vh ----
`ifndef DHB_MAP_VH
`define DHB_MAP_VH
// ****************************************
// Timing constants
// ****************************************
`define DHB_CLK_HZ            10000000
// Times in nanoseconds, as printed
`define DHB_BLANK_NS          1800
`define DHB_OFF_NS            20000
`define DHB_DEG_NS            2800
`define DHB_RETRY_NS          1600000
// Cycle counts at the 100 ns clock, counter width
`define DHB_BLANK_CYC         16'h0012
`define DHB_OFF_CYC           16'h00C8
`define DHB_DEG_CYC           16'h001C
`define DHB_RETRY_CYC         16'h3E80
`define DHB_CNT_W             16
// ****************************************
// Input and chop state encodings
// ****************************************
`define DHB_TRI_LOW           2'h0
`define DHB_TRI_HIGH          2'h1
`define DHB_TRI_Z             2'h2
`define DHB_ST_ON             2'h0
`define DHB_ST_OFF            2'h1
`define DHB_ST_TRIP           2'h2
`define DHB_ST_RETRY          2'h3
`endif

// ---- rtl/dhb_top.v ----
// Behaviour
// - Each bridge maps its inputs 00 coast, 01 reverse, 10 forward, 11 brake.
// - First-bridge inputs are three-level and a floating input is its own state.
// - Outside parallel mode a floating first-bridge input holds that bridge's outputs.
// - Parallel mode is entered only when both first-bridge inputs float at reset or wake.
// - In parallel mode only the second bridge's inputs steer both bridges.
// - Parallel mode stays until a wake sees both first-bridge inputs driven; a reset clears it unless both float.
// - A chop trip turns drive off for the 20 us off time, then a new cycle starts.
// - After drive turns on, the sense comparator is ignored for 1.8 us.
// - Each on phase ended by a chop trip lasts at least the blanking interval.
// - The trip is the comparator decision of sense voltage above reference over 6.6.
// - Overcurrent counts only after it persists for 2.8 us.
// - After overcurrent the bridge stays disabled for 1.6 ms before retrying.
// - Overcurrent disables only the affected bridge (both bridges in parallel mode) and pulls the fault flag low.
// - The fault flag is not latched and releases once operation resumes.
// - Sleep low turns off the regulator and puts all outputs in high impedance.
`timescale 1ns/1ps
module dhb_top (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst,
  // First bridge tri-level inputs, high and low detectors
  input  wire bridge_a_ctrl_first_hi,
  input  wire bridge_a_ctrl_first_lo,
  input  wire bridge_a_ctrl_second_hi,
  input  wire bridge_a_ctrl_second_lo,
  // Second bridge inputs
  input  wire bridge_b_ctrl_first,
  input  wire bridge_b_ctrl_second,
  // Sleep pin
  input  wire sleep_request_low,
  // Chop comparators and overcurrent indications
  input  wire current_sense_node_a_trip,
  input  wire current_sense_node_b_trip,
  input  wire ocp_a_raw,
  input  wire ocp_b_raw,
  // Bridge A outputs
  output reg  bridge_a_drive_first_out,
  output reg  bridge_a_drive_first_oe,
  output reg  bridge_a_drive_second_out,
  output reg  bridge_a_drive_second_oe,
  // Bridge B outputs
  output reg  bridge_b_drive_first_out,
  output reg  bridge_b_drive_first_oe,
  output reg  bridge_b_drive_second_out,
  output reg  bridge_b_drive_second_oe,
  // Open-drain fault flag
  output reg  fault_flag_low_out,
  output reg  fault_flag_low_oe,
  // Regulator enable and mode status
  output reg  internal_regulator_out_en,
  output reg  parallel_mode
);
`include "dhb_map.vh"
  // ****************************************
  // Input synchronisers
  // ****************************************
  wire [1:0] a1_lvl;
  wire [1:0] a2_lvl;
  reg  [1:0] b1_sync_reg;
  reg  [1:0] b2_sync_reg;
  reg  [1:0] slp_sync_reg;
  reg  [1:0] sa_sync_reg;
  reg  [1:0] sb_sync_reg;
  reg  [1:0] oa_sync_reg;
  reg  [1:0] ob_sync_reg;
  reg        awake_reg;
  reg        mode_pend_reg;
  reg        par_reg;
  reg        par_next;
  reg  [1:0] a_hold_reg;
  reg  [1:0] a_hold_next;

  dhb_tri_in u_tri_a1 (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pin_high  (bridge_a_ctrl_first_hi),
    .pin_low   (bridge_a_ctrl_first_lo),
    .level_reg (a1_lvl)
  );

  dhb_tri_in u_tri_a2 (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pin_high  (bridge_a_ctrl_second_hi),
    .pin_low   (bridge_a_ctrl_second_lo),
    .level_reg (a2_lvl)
  );

  // Bridge B levels
  always @(posedge sys_clk) begin
    if (rst) begin
      b1_sync_reg <= 2'h0;
      b2_sync_reg <= 2'h0;
    end else begin
      b1_sync_reg <= {b1_sync_reg[0], bridge_b_ctrl_first};
      b2_sync_reg <= {b2_sync_reg[0], bridge_b_ctrl_second};
    end
  end

  // Sleep pin
  always @(posedge sys_clk) begin
    if (rst) begin
      slp_sync_reg <= 2'h0;
    end else begin
      slp_sync_reg <= {slp_sync_reg[0], sleep_request_low};
    end
  end

  // Chop comparators
  always @(posedge sys_clk) begin
    if (rst) begin
      sa_sync_reg <= 2'h0;
      sb_sync_reg <= 2'h0;
    end else begin
      sa_sync_reg <= {sa_sync_reg[0], current_sense_node_a_trip};
      sb_sync_reg <= {sb_sync_reg[0], current_sense_node_b_trip};
    end
  end

  // Overcurrent indications
  always @(posedge sys_clk) begin
    if (rst) begin
      oa_sync_reg <= 2'h0;
      ob_sync_reg <= 2'h0;
    end else begin
      oa_sync_reg <= {oa_sync_reg[0], ocp_a_raw};
      ob_sync_reg <= {ob_sync_reg[0], ocp_b_raw};
    end
  end

  wire awake   = slp_sync_reg[1];
  wire a_float = (a1_lvl == `DHB_TRI_Z) && (a2_lvl == `DHB_TRI_Z);
  wire a_drven = (a1_lvl != `DHB_TRI_Z) && (a2_lvl != `DHB_TRI_Z);

  // ****************************************
  // Parallel mode capture at reset release and wake
  // ****************************************
  // Sampling waits until the tri-level samplers have settled
  reg [2:0] settle_reg;
  wire      settled = (settle_reg == 3'h4);

  always @(posedge sys_clk) begin
    if (rst) begin
      awake_reg     <= 1'b0;
      mode_pend_reg <= 1'b1;
      settle_reg    <= 3'h0;
      par_reg       <= 1'b0;
    end else begin
      awake_reg <= awake;
      if (!settled)
        settle_reg <= settle_reg + 3'h1;
      if (awake && !awake_reg)
        mode_pend_reg <= 1'b1;
      else if (mode_pend_reg && settled && awake)
        mode_pend_reg <= 1'b0;
      par_reg <= par_next;
    end
  end

  always @* begin
    par_next = par_reg;
    if (mode_pend_reg && settled && awake) begin
      if (a_float)
        par_next = 1'b1;
      else if (a_drven)
        par_next = 1'b0;
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  wire [1:0] b_cmd = {b1_sync_reg[1], b2_sync_reg[1]};
  wire [1:0] a_new = {(a1_lvl == `DHB_TRI_HIGH), (a2_lvl == `DHB_TRI_HIGH)};
  wire       a_any_z = (a1_lvl == `DHB_TRI_Z) || (a2_lvl == `DHB_TRI_Z);

  always @* begin
    a_hold_next = a_hold_reg;
    if (par_reg)
      a_hold_next = b_cmd;
    else if (!a_any_z)
      a_hold_next = a_new;
  end

  always @(posedge sys_clk) begin
    if (rst)
      a_hold_reg <= 2'h0;
    else
      a_hold_reg <= a_hold_next;
  end

  // ****************************************
  // Chopping and overcurrent
  // ****************************************
  wire en_a;
  wire en_b;
  wire flt_a;
  wire flt_b;
  wire trip_a = par_reg ? (sa_sync_reg[1] | sb_sync_reg[1]) : sa_sync_reg[1];

  dhb_chop u_chop_a (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .run        (awake),
    .sense_trip (trip_a),
    .ocp_raw    (oa_sync_reg[1]),
    .drive_en   (en_a),
    .ocp_fault  (flt_a)
  );

  dhb_chop u_chop_b (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .run        (awake),
    .sense_trip (sb_sync_reg[1]),
    .ocp_raw    (ob_sync_reg[1]),
    .drive_en   (en_b),
    .ocp_fault  (flt_b)
  );

  // Shared chop in parallel mode, a fault on either bridge disables both bridges
  wire go_a = par_reg ? (en_a && !flt_b) : en_a;
  wire go_b = par_reg ? (en_a && !flt_b) : en_b;

  // ****************************************
  // Output stage
  // ****************************************
  // Drive codes {first_out, first_oe, second_out, second_oe}
  localparam [3:0] DRV_COAST   = 4'h0;
  localparam [3:0] DRV_REVERSE = 4'h7;
  localparam [3:0] DRV_FORWARD = 4'hD;
  localparam [3:0] DRV_BRAKE   = 4'h5;

  reg  [3:0] a_drv;
  reg  [3:0] b_drv;
  wire       a_live = go_a && awake;
  wire       b_live = go_b && awake;

  // Bridge A decode from held command
  always @* begin
    if (!a_live) begin
      a_drv = DRV_COAST;
    end else begin
      case (a_hold_next)
        2'h0:    a_drv = DRV_COAST;
        2'h1:    a_drv = DRV_REVERSE;
        2'h2:    a_drv = DRV_FORWARD;
        2'h3:    a_drv = DRV_BRAKE;
        default: a_drv = DRV_COAST;
      endcase
    end
  end

  // Bridge B decode
  always @* begin
    if (!b_live) begin
      b_drv = DRV_COAST;
    end else begin
      case (b_cmd)
        2'h0:    b_drv = DRV_COAST;
        2'h1:    b_drv = DRV_REVERSE;
        2'h2:    b_drv = DRV_FORWARD;
        2'h3:    b_drv = DRV_BRAKE;
        default: b_drv = DRV_COAST;
      endcase
    end
  end

  // Bridge A output registers
  always @(posedge sys_clk) begin
    if (rst) begin
      bridge_a_drive_first_out  <= 1'b0;
      bridge_a_drive_first_oe   <= 1'b0;
      bridge_a_drive_second_out <= 1'b0;
      bridge_a_drive_second_oe  <= 1'b0;
    end else begin
      bridge_a_drive_first_out  <= a_drv[3];
      bridge_a_drive_first_oe   <= a_drv[2];
      bridge_a_drive_second_out <= a_drv[1];
      bridge_a_drive_second_oe  <= a_drv[0];
    end
  end

  // Bridge B output registers
  always @(posedge sys_clk) begin
    if (rst) begin
      bridge_b_drive_first_out  <= 1'b0;
      bridge_b_drive_first_oe   <= 1'b0;
      bridge_b_drive_second_out <= 1'b0;
      bridge_b_drive_second_oe  <= 1'b0;
    end else begin
      bridge_b_drive_first_out  <= b_drv[3];
      bridge_b_drive_first_oe   <= b_drv[2];
      bridge_b_drive_second_out <= b_drv[1];
      bridge_b_drive_second_oe  <= b_drv[0];
    end
  end

  // Status registers
  always @(posedge sys_clk) begin
    if (rst) begin
      fault_flag_low_out        <= 1'b0;
      fault_flag_low_oe         <= 1'b0;
      internal_regulator_out_en <= 1'b0;
      parallel_mode             <= 1'b0;
    end else begin
      fault_flag_low_out        <= 1'b0;
      fault_flag_low_oe         <= flt_a | flt_b;
      internal_regulator_out_en <= awake;
      parallel_mode             <= par_reg;
    end
  end
endmodule // dhb_top

// ---- rtl/dhb_tri_in.v ----
`timescale 1ns/1ps
// ****************************************
// Tri-level input sampler
// ****************************************
module dhb_tri_in (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Pin detectors
  input  wire       pin_high,
  input  wire       pin_low,
  // Decoded level
  output reg  [1:0] level_reg
);
`include "dhb_map.vh"
  reg [1:0] hi_sync_reg;
  reg [1:0] lo_sync_reg;
  reg [1:0] level_next;

  always @(posedge sys_clk) begin
    if (rst) begin
      hi_sync_reg <= 2'h0;
      lo_sync_reg <= 2'h0;
      level_reg   <= `DHB_TRI_LOW;
    end else begin
      hi_sync_reg <= {hi_sync_reg[0], pin_high};
      lo_sync_reg <= {lo_sync_reg[0], pin_low};
      level_reg   <= level_next;
    end
  end

  // Neither detector set means floating
  always @* begin
    if (hi_sync_reg[1])
      level_next = `DHB_TRI_HIGH;
    else if (lo_sync_reg[1])
      level_next = `DHB_TRI_LOW;
    else
      level_next = `DHB_TRI_Z;
  end
endmodule // dhb_tri_in

// ---- testbench/dhb_ctrl_model.sv ----
`timescale 1ns/1ps
`include "dhb_map.vh"
// ****************************************
// Controller model driving the bridge inputs
// ****************************************
module dhb_ctrl_model (
  // Clock
  input  wire       sys_clk,
  // Requested levels, tri codes for bridge A
  input  wire [1:0] a1_cmd,
  input  wire [1:0] a2_cmd,
  input  wire       b1_cmd,
  input  wire       b2_cmd,
  // Pin levels seen by the device
  output reg        bridge_a_ctrl_first_hi,
  output reg        bridge_a_ctrl_first_lo,
  output reg        bridge_a_ctrl_second_hi,
  output reg        bridge_a_ctrl_second_lo,
  output reg        bridge_b_ctrl_first,
  output reg        bridge_b_ctrl_second
);
  // Floating pin shows neither detector
  always @(posedge sys_clk) begin
    bridge_a_ctrl_first_hi  <= (a1_cmd == `DHB_TRI_HIGH);
    bridge_a_ctrl_first_lo  <= (a1_cmd == `DHB_TRI_LOW);
    bridge_a_ctrl_second_hi <= (a2_cmd == `DHB_TRI_HIGH);
    bridge_a_ctrl_second_lo <= (a2_cmd == `DHB_TRI_LOW);
    bridge_b_ctrl_first     <= b1_cmd;
    bridge_b_ctrl_second    <= b2_cmd;
  end
endmodule // dhb_ctrl_model

// ---- testbench/dhb_top_assertions.sv ----
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module dhb_top_chk (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Inputs watched
  input wire sleep_request_low,
  input wire ocp_a_raw,
  input wire ocp_b_raw,
  // Outputs
  input wire bridge_a_drive_first_out,
  input wire bridge_a_drive_first_oe,
  input wire bridge_a_drive_second_out,
  input wire bridge_a_drive_second_oe,
  input wire bridge_b_drive_first_out,
  input wire bridge_b_drive_first_oe,
  input wire bridge_b_drive_second_out,
  input wire bridge_b_drive_second_oe,
  input wire fault_flag_low_out,
  input wire fault_flag_low_oe,
  input wire internal_regulator_out_en,
  input wire parallel_mode
);
  logic [7:0]  run_a, run_b;
  logic        ocp_a_q, ocp_b_q;
  logic [15:0] flt_cnt;
  logic [4:0]  evt_cnt;
  wire  [3:0]  obs_a = {bridge_a_drive_first_oe, bridge_a_drive_first_out & bridge_a_drive_first_oe,
                        bridge_a_drive_second_oe, bridge_a_drive_second_out & bridge_a_drive_second_oe};
  wire  [3:0]  obs_b = {bridge_b_drive_first_oe, bridge_b_drive_first_out & bridge_b_drive_first_oe,
                        bridge_b_drive_second_oe, bridge_b_drive_second_out & bridge_b_drive_second_oe};

  // Length of latest overcurrent burst, fault spell, time since wake
  always @(posedge sys_clk) begin
    ocp_a_q <= ocp_a_raw;
    ocp_b_q <= ocp_b_raw;
    run_a   <= rst ? 8'h00 : (ocp_a_raw ? (ocp_a_q ? run_a + 8'h01 : 8'h01) : run_a);
    run_b   <= rst ? 8'h00 : (ocp_b_raw ? (ocp_b_q ? run_b + 8'h01 : 8'h01) : run_b);
    flt_cnt <= (rst || !fault_flag_low_oe) ? 16'h0000 : flt_cnt + 16'h0001;
    evt_cnt <= (rst || !sleep_request_low) ? 5'h00 : evt_cnt + {4'h0, evt_cnt != 5'h1F};
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  no_shoot_a: assert property (obs_a[3] == obs_a[1] && obs_b[3] == obs_b[1]
    && !(obs_a[2] && obs_a[0]) && !(obs_b[2] && obs_b[0])) else $error("bridge half driven");
  sleep_hiz_a: assert property (!sleep_request_low [*4] |-> obs_a == 4'h0 && obs_b == 4'h0
    && !internal_regulator_out_en) else $error("sleep left drive or regulator on");
  wake_reg_a: assert property (sleep_request_low [*5] |-> internal_regulator_out_en)
    else $error("regulator off while awake");
  mode_hold_a: assert property ($changed(parallel_mode) |-> evt_cnt < 5'h0C)
    else $error("mode changed away from wake");
  par_mirror_a: assert property (parallel_mode && $past(parallel_mode, 4)
    |-> obs_a == obs_b || obs_a == $past(obs_b)) else $error("bridges differ in parallel");
  ocp_filter_a: assert property ($rose(fault_flag_low_oe) |-> run_a >= 8'h1C || run_b >= 8'h1C)
    else $error("fault on short overcurrent");
  fault_bridge_a: assert property (fault_flag_low_oe && $past(fault_flag_low_oe, 2)
    |-> !fault_flag_low_out && (obs_a == 4'h0 || obs_b == 4'h0)) else $error("fault without stop");
  retry_len_a: assert property ($fell(fault_flag_low_oe) && sleep_request_low
    |-> flt_cnt inside {[16'h3E7D:16'h3E82]}) else $error("retry period wrong");
  flt_release_a: assert property (fault_flag_low_oe |-> flt_cnt < 16'h3E83)
    else $error("fault flag held too long");

  cov_par: cover property ($rose(parallel_mode));
  cov_fault: cover property ($rose(fault_flag_low_oe));
  cov_chop: cover property ($fell(obs_b[3]) && sleep_request_low);
endmodule // dhb_top_chk

bind dhb_top dhb_top_chk u_chk (.*);

// ---- testbench/dual_hbridge_pwm_control_tb.sv ----
`timescale 1ns/1ps
`include "dhb_map.vh"
module dual_hbridge_pwm_control_tb;
  logic       sys_clk = 1'b0, rst = 1'b1, sleep_request_low = 1'b1;
  logic       current_sense_node_a_trip = 1'b0, current_sense_node_b_trip = 1'b0;
  logic       ocp_a_raw = 1'b0, ocp_b_raw = 1'b0, b1_cmd = 1'b0, b2_cmd = 1'b0;
  logic [1:0] a1_cmd = `DHB_TRI_LOW, a2_cmd = `DHB_TRI_LOW;
  wire        bridge_a_ctrl_first_hi, bridge_a_ctrl_first_lo, bridge_a_ctrl_second_hi;
  wire        bridge_a_ctrl_second_lo, bridge_b_ctrl_first, bridge_b_ctrl_second;
  wire        bridge_a_drive_first_out, bridge_a_drive_first_oe, bridge_a_drive_second_out;
  wire        bridge_a_drive_second_oe, bridge_b_drive_first_out, bridge_b_drive_first_oe;
  wire        bridge_b_drive_second_out, bridge_b_drive_second_oe, fault_flag_low_out;
  wire        fault_flag_low_oe, internal_regulator_out_en, parallel_mode;
  int         bad_count = 0, cmp_count = 0, ea = 0, eb = 0, n, i, ax, ay, bx, by;
  wire  [3:0] obs_a = {bridge_a_drive_first_oe, bridge_a_drive_first_out & bridge_a_drive_first_oe,
                       bridge_a_drive_second_oe, bridge_a_drive_second_out & bridge_a_drive_second_oe};
  wire  [3:0] obs_b = {bridge_b_drive_first_oe, bridge_b_drive_first_out & bridge_b_drive_first_oe,
                       bridge_b_drive_second_oe, bridge_b_drive_second_out & bridge_b_drive_second_oe};

  always #50 sys_clk = ~sys_clk;
  dhb_ctrl_model u_ctrl (.*);
  dhb_top uut (.*);

  // ****************************************
  // Model and helpers
  // ****************************************
  function automatic [3:0] tab(input int f, input int s);
    case ({f[0], s[0]})
      2'b01: return 4'hB;
      2'b10: return 4'hE;
      2'b11: return 4'hA;
      default: return 4'h0;
    endcase
  endfunction
  function logic pick(input int s);
    return s ? fault_flag_low_oe : bridge_b_drive_first_oe;
  endfunction
  task wt(input int k);
    repeat (k) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task chk(input string nm, input [3:0] e, input [3:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rng(input string nm, input int lo, input int hi, input int v);
    cmp_count++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask
  task waitv(input int s, input logic v, input int lim, output int k);
    k = 0;
    while (pick(s) !== v && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
  endtask
  task drive(input int p, input int q, input int r, input int t);
    @(posedge sys_clk);
    a1_cmd <= p[1:0];
    a2_cmd <= q[1:0];
    b1_cmd <= r[0];
    b2_cmd <= t[0];
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #4000000;
    bad_count++;
    $display("watchdog expired");
    tally_and_finish;
  end

  initial begin
    n = $urandom(32'h9BF6954E);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    wt(8);
    for (i = 0; i < 44; i++) begin
      ax = i < 4 ? i[1] : $urandom % 3;
      ay = i < 4 ? i[0] : $urandom % 3;
      bx = i < 4 ? i[1] : $urandom % 2;
      by = i < 4 ? i[0] : $urandom % 2;
      drive(ax, ay, bx, by);
      if (ax != `DHB_TRI_Z && ay != `DHB_TRI_Z) ea = tab(ax, ay);
      eb = tab(bx, by);
      wt(8);
      chk("bridge a", ea[3:0], obs_a);
      chk("bridge b", eb[3:0], obs_b);
    end
    $display("decode test done");
    drive(`DHB_TRI_HIGH, `DHB_TRI_LOW, 1, 0);
    ea = tab(1, 0);
    eb = ea;
    wt(8);
    @(posedge sys_clk);
    current_sense_node_b_trip <= 1'b1;
    waitv(0, 1'b0, 100, n);
    waitv(0, 1'b1, 400, n);
    rng("off time", 200, 202, n);
    waitv(0, 1'b0, 100, n);
    rng("on time", 18, 22, n);
    chk("bridge a chop", ea[3:0], obs_a);
    @(posedge sys_clk);
    current_sense_node_b_trip <= 1'b0;
    wt(210);
    chk("chop end", eb[3:0], obs_b);
    $display("chop test done");
    @(posedge sys_clk);
    ocp_b_raw <= 1'b1;
    wt(19);
    @(posedge sys_clk);
    ocp_b_raw <= 1'b0;
    wt(10);
    chk("glitch", 4'h0, {3'h0, fault_flag_low_oe});
    @(posedge sys_clk);
    ocp_b_raw <= 1'b1;
    waitv(1, 1'b1, 60, n);
    rng("deglitch", 28, 34, n);
    wt(2);
    chk("ocp b off", 4'h0, obs_b);
    chk("ocp a on", ea[3:0], obs_a);
    @(posedge sys_clk);
    ocp_b_raw <= 1'b0;
    waitv(1, 1'b0, 17000, n);
    rng("retry", 15990, 16002, n);
    wt(8);
    chk("resume", eb[3:0], obs_b);
    chk("fault released", 4'h0, {3'h0, fault_flag_low_oe});
    $display("overcurrent test done");
    @(posedge sys_clk);
    sleep_request_low <= 1'b0;
    drive(`DHB_TRI_Z, `DHB_TRI_Z, 1, 0);
    wt(8);
    chk("sleep a", 4'h0, obs_a);
    chk("sleep b", 4'h0, obs_b);
    chk("regulator", 4'h0, {3'h0, internal_regulator_out_en});
    @(posedge sys_clk);
    sleep_request_low <= 1'b1;
    wt(12);
    chk("parallel on", 4'h1, {3'h0, parallel_mode});
    for (i = 0; i < 4; i++) begin
      drive(i[0] ? `DHB_TRI_LOW : `DHB_TRI_HIGH, `DHB_TRI_LOW, i[1], i[0]);
      eb = tab(i[1], i[0]);
      wt(8);
      chk("parallel a", eb[3:0], obs_a);
      chk("parallel b", eb[3:0], obs_b);
    end
    chk("parallel kept", 4'h1, {3'h0, parallel_mode});
    @(posedge sys_clk);
    sleep_request_low <= 1'b0;
    drive(`DHB_TRI_HIGH, `DHB_TRI_LOW, 0, 1);
    wt(8);
    @(posedge sys_clk);
    sleep_request_low <= 1'b1;
    wt(12);
    chk("parallel off", 4'h0, {3'h0, parallel_mode});
    chk("normal a", tab(1, 0), obs_a);
    chk("normal b", tab(0, 1), obs_b);
    $display("sleep test done");
    tally_and_finish;
  end
endmodule // dual_hbridge_pwm_control_tb
